// file: rtl/csc_fifo.sv
// Small command byte FIFO with registered full flag
`timescale 1ns/1ns
module csc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   csc_strm_if.snk s,
   csc_strm_if.src m
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic full;
   } csc_fifo_s;

   csc_fifo_s q;
   csc_fifo_s d;
   logic push;
   logic pop;

   always_comb
   begin
      d = q;
      push = s.valid && !q.full;
      pop = m.ready && (q.cnt != '0);
      if (push)
      begin
         d.mem[q.wr] = s.data;
         d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
      end
      if (pop)
      begin
         d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
      end
      d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      d.full = (d.cnt == (AW + 1)'(DEPTH));
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign s.ready = !q.full;
   assign m.valid = (q.cnt != '0);
   assign m.data = q.mem[q.rd];
endmodule

// file: rtl/csc_host.sv
// Terminal-side controller: card clock, reset, answer parsing, command stream
`timescale 1ns/1ns
// How it works
// R01: Card is busy during commands, idle otherwise
// R02: Clock stops only when the card allows it
// R03: Wait 1860 clocks after last character before stop
// R04: Wait 744 clocks after restart before sending
// R05: Card answers normal completion to power-down
// R06: Later-phase terminal never sends power-down command
// R07: Early-phase terminal waits 744 clocks before stop
// R08: Answer bits timed at clock divided by 372
// R09: Keep 372 unless negotiation succeeded
// R10: Answer holds at most 33 characters
// R11: Accept other-protocol, historical and check characters
// R12: Initial character sets the coding convention
// R13: Format character announces following characters
// R14: Speed character not 11 requires negotiation
// R15: Nonzero programming voltage index rejects answer
// R16: Guard character not 0 or 255 rejects
// R17: Card never sends programming-voltage character
// R18: Apply the work waiting time character
// R19: Each protocol indicator sets following characters
// R20: Check character present unless only T=0
// R21: Guard 255 means 12 etu between characters
// R22: Retry reset; reject after three faulty answers
// R23: Clock counter cleared per event enforces waits
module csc_host #(
   parameter int ATR_WAIT_CYC = csc_pkg::ATR_WAIT_DEFAULT,
   parameter bit EARLY_PHASE = 1'b0,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic START_I,
   input wire logic STOP_ALLOWED_I,
   input wire logic CLK_STOP_REQ_I,
   input wire logic NEG_DONE_I,
   input wire logic [9:0] NEG_ETU_I,
   input wire logic [7:0] TX_DATA_I,
   input wire logic TX_VALID_I,
   output logic TX_READY_O,
   input wire logic IO_I,
   output logic IO_O,
   output logic IO_OE_N_O,
   output logic CARD_CLK_O,
   output logic CARD_RST_O,
   output logic [7:0] RX_DATA_O,
   output logic RX_VALID_O,
   output logic SESSION_READY_O,
   output logic SPEED_NEG_REQ_O,
   output logic [7:0] SPEED_CHAR_O,
   output logic [7:0] WWI_O,
   output logic INVERSE_O,
   output logic CLK_STOPPED_O,
   output logic CARD_REJECTED_O
);
   typedef struct packed {
      csc_pkg::csc_state_e st;
      csc_pkg::csc_phase_e ph;
      logic [2:0] div;
      logic cclk;
      logic card_rst;
      logic [9:0] etu_div;
      logic [9:0] etu_cnt;
      logic [12:0] gap;
      logic [21:0] wait_cnt;
      logic rx_arm;
      logic rx_busy;
      logic rx_done;
      logic [3:0] rx_bit;
      logic [9:0] rx_sh;
      logic tx_busy;
      logic [3:0] tx_bit;
      logic [11:0] tx_sh;
      logic io_o;
      logic io_oe_n;
      logic inverse;
      logic [3:0] y;
      logic [3:0] k;
      logic [2:0] idx;
      logic tck_need;
      logic [7:0] xsum;
      logic [5:0] nchar;
      logic fault;
      logic [1:0] faults;
      logic [7:0] ta1;
      logic ta1_seen;
      logic [7:0] wwi;
      logic [7:0] rx_data;
      logic rx_valid;
      logic ready;
      logic need_neg;
      logic stopped;
      logic rejected;
   } csc_host_s;

   csc_host_s q;
   csc_host_s d;
   logic io_s;
   logic tick;
   logic etu_end;
   logic pop;
   logic parity_ok;
   logic [7:0] raw;
   logic [7:0] dat;
   logic [7:0] txb;
   logic [3:0] ny;
   logic [12:0] stop_need;
   logic fin;

   csc_strm_if #(.W(8)) in_if ();
   csc_strm_if #(.W(8)) out_if ();

   // ==========================================================
   // Input synchroniser and command FIFO
   csc_sync u_io_sync (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .d_i(IO_I),
      .q_o(io_s)
   );

   assign in_if.data = TX_DATA_I;
   assign in_if.valid = TX_VALID_I;
   assign TX_READY_O = in_if.ready;
   assign out_if.ready = pop;

   csc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .s(in_if.snk),
      .m(out_if.src)
   );

   // Parse step after each format, interface or historical character
   function automatic csc_pkg::csc_phase_e next_ph(logic [3:0] y, logic [3:0] k, logic t);
      if (y != 4'h0)
      begin
         return csc_pkg::PH_IF;
      end
      else if (k != 4'h0)
      begin
         return csc_pkg::PH_HIST;
      end
      else if (t)
      begin
         return csc_pkg::PH_TCK;
      end
      return csc_pkg::PH_DONE;
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      d = q;
      tick = 1'b0;
      pop = 1'b0;
      fin = 1'b0;
      ny = q.y;
      d.rx_valid = 1'b0;
      d.rx_done = 1'b0;
      raw = q.rx_sh[8:1];
      for (int j = 0; j < 8; j++)
      begin
         dat[7 - j] = ~raw[j];
      end
      if (!q.inverse)
      begin
         dat = raw; // R12
      end
      parity_ok = q.inverse ? (^q.rx_sh[9:1]) : !(^q.rx_sh[9:1]);
      txb = out_if.data;
      stop_need = (EARLY_PHASE ? csc_pkg::LEGACY_STOP_WAIT_CYC : csc_pkg::STOP_WAIT_CYC) // R03 R07
         + {3'h0, q.etu_div} * csc_pkg::TAIL_ETU;

      // Card clock divider, frozen low when stopped or inactive
      if (q.st == csc_pkg::ST_OFF || q.st == csc_pkg::ST_STOPPED || q.st == csc_pkg::ST_REJECT)
      begin
         d.div = 3'h0;
         d.cclk = 1'b0;
      end
      else if (q.div == csc_pkg::CARD_HALF_LAST)
      begin
         d.div = 3'h0;
         d.cclk = !q.cclk;
         tick = !q.cclk;
      end
      else
      begin
         d.div = q.div + 3'h1;
      end

      // Card clock counter since the last qualifying event
      if (tick && q.gap != 13'h1FFF)
      begin
         d.gap = q.gap + 13'h0001; // R23
      end
      etu_end = tick && (q.etu_cnt == 10'h001);
      if (etu_end)
      begin
         d.etu_cnt = q.etu_div; // R08 R09
      end
      else if (tick && q.etu_cnt != 10'h000)
      begin
         d.etu_cnt = q.etu_cnt - 10'h001;
      end

      // ==========================================================
      // Receiver: start edge, mid-bit samples
      if (!q.rx_busy)
      begin
         if (io_s)
         begin
            d.rx_arm = 1'b1;
         end
         if (q.rx_arm && !io_s && !q.tx_busy &&
             (q.st == csc_pkg::ST_ATR || q.st == csc_pkg::ST_READY))
         begin
            d.rx_busy = 1'b1;
            d.rx_arm = 1'b0;
            d.rx_bit = 4'h0;
            d.etu_cnt = {1'b0, q.etu_div[9:1]};
         end
      end
      else if (etu_end)
      begin
         d.rx_sh[q.rx_bit] = io_s;
         d.rx_bit = q.rx_bit + 4'h1;
         if (q.rx_bit == 4'h0 && io_s)
         begin
            d.rx_busy = 1'b0;
         end
         if (q.rx_bit == csc_pkg::PARITY_BIT)
         begin
            d.rx_busy = 1'b0;
            d.rx_done = 1'b1;
            d.gap = 13'h0000; // R23
         end
      end

      // ==========================================================
      // Transmitter: user bytes only, so no power-down command is generated
      if (!q.tx_busy)
      begin
         if (q.st == csc_pkg::ST_READY && !q.rx_busy && q.rx_arm && out_if.valid) // R04 R06
         begin
            pop = 1'b1;
            d.tx_busy = 1'b1;
            d.tx_bit = 4'h0;
            d.etu_cnt = q.etu_div;
            d.io_oe_n = 1'b0;
            if (q.inverse)
            begin
               d.tx_sh = {2'b11, ^txb, {<<{txb}}, 1'b0};
               d.tx_sh[9:1] = ~d.tx_sh[9:1];
            end
            else
            begin
               d.tx_sh = {2'b11, ^txb, txb, 1'b0};
            end
         end
      end
      else if (etu_end)
      begin
         d.tx_sh = {1'b1, q.tx_sh[11:1]};
         d.io_oe_n = q.tx_sh[1];
         d.tx_bit = q.tx_bit + 4'h1;
         if (q.tx_bit == csc_pkg::FRAME_BITS + csc_pkg::GUARD_BITS - 4'h1) // R21
         begin
            d.tx_busy = 1'b0;
            d.io_oe_n = 1'b1;
            d.gap = 13'h0000;
         end
      end

      // ==========================================================
      // Session sequence
      case (q.st)
         csc_pkg::ST_OFF:
         begin
            d.card_rst = 1'b0;
            if (START_I)
            begin
               d.st = csc_pkg::ST_RST;
               d.wait_cnt = 22'h000000;
            end
         end
         csc_pkg::ST_RST:
         begin
            d.card_rst = 1'b0;
            d.ready = 1'b0;
            if (tick)
            begin
               d.wait_cnt = q.wait_cnt + 22'h000001;
            end
            if (q.wait_cnt >= csc_pkg::RST_LOW_CYC)
            begin
               d.card_rst = 1'b1;
               d.st = csc_pkg::ST_ATR;
               d.ph = csc_pkg::PH_TS;
               d.wait_cnt = 22'h000000;
               d.nchar = 6'h00;
               d.fault = 1'b0;
               d.tck_need = 1'b0;
               d.ta1_seen = 1'b0;
               d.ta1 = csc_pkg::TA1_DEFAULT;
               d.wwi = csc_pkg::WWI_DEFAULT;
               d.xsum = 8'h00;
               d.inverse = 1'b0;
               d.etu_div = csc_pkg::ETU_DEFAULT; // R08
               d.rx_arm = 1'b0;
            end
         end
         csc_pkg::ST_ATR:
         begin
            if (tick)
            begin
               d.wait_cnt = q.wait_cnt + 22'h000001;
            end
            if (q.rx_done)
            begin
               d.wait_cnt = 22'h000000;
               d.nchar = q.nchar + 6'h01;
               if (q.nchar == csc_pkg::ATR_MAX_CHARS)
               begin
                  d.fault = 1'b1; // R10
               end
               if (q.ph != csc_pkg::PH_TS)
               begin
                  d.xsum = q.xsum ^ dat;
                  if (!parity_ok)
                  begin
                     d.fault = 1'b1;
                  end
               end
               case (q.ph)
                  csc_pkg::PH_TS:
                  begin
                     d.ph = csc_pkg::PH_T0;
                     if (raw == csc_pkg::TS_INVERSE_RAW)
                     begin
                        d.inverse = 1'b1; // R12
                     end
                     else if (raw != csc_pkg::TS_DIRECT_RAW)
                     begin
                        d.fault = 1'b1;
                     end
                  end
                  csc_pkg::PH_T0:
                  begin
                     d.y = dat[7:4]; // R13
                     d.k = dat[3:0];
                     d.idx = 3'h1;
                     d.ph = next_ph(dat[7:4], dat[3:0], 1'b0);
                  end
                  csc_pkg::PH_IF:
                  begin
                     if (q.y[0])
                     begin
                        ny[0] = 1'b0;
                        if (q.idx == 3'h1)
                        begin
                           d.ta1 = dat;
                           d.ta1_seen = 1'b1;
                        end
                     end
                     else if (q.y[1])
                     begin
                        ny[1] = 1'b0;
                        if (q.idx == 3'h1 && dat[4:0] != 5'h00)
                        begin
                           d.fault = 1'b1; // R15
                        end
                     end
                     else if (q.y[2])
                     begin
                        ny[2] = 1'b0;
                        if (q.idx == 3'h1 && dat != csc_pkg::EGT_NONE &&
                            dat != csc_pkg::EGT_MIN_DELAY)
                        begin
                           d.fault = 1'b1; // R16
                        end
                        if (q.idx == 3'h2)
                        begin
                           d.wwi = dat; // R18
                        end
                     end
                     else
                     begin
                        ny = dat[7:4]; // R19
                        d.idx = q.idx + 3'h1;
                        if (dat[3:0] != 4'h0)
                        begin
                           d.tck_need = 1'b1; // R11 R20
                        end
                     end
                     d.y = ny;
                     d.ph = next_ph(ny, q.k, d.tck_need);
                  end
                  csc_pkg::PH_HIST:
                  begin
                     d.k = q.k - 4'h1; // R11
                     d.ph = next_ph(4'h0, d.k, q.tck_need);
                  end
                  csc_pkg::PH_TCK:
                  begin
                     d.ph = csc_pkg::PH_DONE;
                     if ((q.xsum ^ dat) != 8'h00)
                     begin
                        d.fault = 1'b1; // R20
                     end
                  end
                  default:
                  begin
                     d.ph = csc_pkg::PH_DONE;
                  end
               endcase
            end
            fin = (q.ph == csc_pkg::PH_DONE) || q.fault || (q.wait_cnt >= 22'(ATR_WAIT_CYC));
            if (fin)
            begin
               if (q.fault || q.ph != csc_pkg::PH_DONE)
               begin
                  if (q.faults == csc_pkg::MAX_FAULTS - 2'h1)
                  begin
                     d.st = csc_pkg::ST_REJECT; // R22
                     d.rejected = 1'b1;
                  end
                  else
                  begin
                     d.faults = q.faults + 2'h1; // R22
                     d.st = csc_pkg::ST_RST;
                     d.card_rst = 1'b0;
                     d.wait_cnt = 22'h000000;
                  end
               end
               else
               begin
                  d.st = csc_pkg::ST_READY;
                  d.ready = 1'b1;
                  d.faults = 2'h0;
                  d.need_neg = q.ta1_seen && (q.ta1 != csc_pkg::TA1_DEFAULT); // R14
               end
            end
         end
         csc_pkg::ST_READY:
         begin
            if (q.rx_done)
            begin
               d.rx_data = dat;
               d.rx_valid = 1'b1;
            end
            if (NEG_DONE_I)
            begin
               d.etu_div = NEG_ETU_I; // R09
               d.need_neg = 1'b0;
            end
            // Stop only in a low phase that is not about to end, so no high pulse is cut short
            if (CLK_STOP_REQ_I && STOP_ALLOWED_I && !q.rx_busy && !q.tx_busy && // R02
                !q.cclk && q.div != csc_pkg::CARD_HALF_LAST &&
                !q.rx_done && q.gap >= stop_need) // R03 R07
            begin
               d.st = csc_pkg::ST_STOPPED;
               d.stopped = 1'b1;
            end
         end
         csc_pkg::ST_STOPPED:
         begin
            if (!CLK_STOP_REQ_I)
            begin
               d.st = csc_pkg::ST_WAKE;
               d.stopped = 1'b0;
               d.gap = 13'h0000; // R23
            end
         end
         csc_pkg::ST_WAKE:
         begin
            if (q.gap >= csc_pkg::WAKE_WAIT_CYC)
            begin
               d.st = csc_pkg::ST_READY; // R04
            end
         end
         default:
         begin
            d.card_rst = 1'b0;
         end
      endcase

      // Deactivation from any state
      if (!START_I)
      begin
         d.st = csc_pkg::ST_OFF;
         d.card_rst = 1'b0;
         d.faults = 2'h0;
         d.ready = 1'b0;
         d.need_neg = 1'b0;
         d.stopped = 1'b0;
         d.rejected = 1'b0;
         d.rx_busy = 1'b0;
         d.tx_busy = 1'b0;
         d.io_oe_n = 1'b1;
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         q <= '0;
         q.st <= csc_pkg::ST_OFF;
         q.ph <= csc_pkg::PH_TS;
         q.io_oe_n <= 1'b1;
         q.etu_div <= csc_pkg::ETU_DEFAULT;
         q.ta1 <= csc_pkg::TA1_DEFAULT;
         q.wwi <= csc_pkg::WWI_DEFAULT;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign IO_O = q.io_o;
   assign IO_OE_N_O = q.io_oe_n;
   assign CARD_CLK_O = q.cclk;
   assign CARD_RST_O = q.card_rst;
   assign RX_DATA_O = q.rx_data;
   assign RX_VALID_O = q.rx_valid;
   assign SESSION_READY_O = q.ready;
   assign SPEED_NEG_REQ_O = q.need_neg;
   assign SPEED_CHAR_O = q.ta1;
   assign WWI_O = q.wwi;
   assign INVERSE_O = q.inverse;
   assign CLK_STOPPED_O = q.stopped;
   assign CARD_REJECTED_O = q.rejected;
endmodule

// file: rtl/csc_pkg.sv
// Shared constants and types of the card session host controller
package csc_pkg;
   // Last divider count of the 4 master clocks per card clock half period (card clock = MCLK / 8)
   localparam logic [2:0] CARD_HALF_LAST = 3'h3;
   // Card clocks per etu before and without speed negotiation (372)
   localparam logic [9:0] ETU_DEFAULT = 10'h174;
   // Card clocks after the last response character before clock stop (1 860)
   localparam logic [12:0] STOP_WAIT_CYC = 13'h0744;
   // Card clocks for the early-phase stop wait and the wake-up wait (744)
   localparam logic [12:0] LEGACY_STOP_WAIT_CYC = 13'h02E8;
   localparam logic [12:0] WAKE_WAIT_CYC = 13'h02E8;
   // Etus after the parity sample that cover the rest of the character and its guard
   localparam logic [12:0] TAIL_ETU = 13'h0003;
   // Card clocks with reset held low (400)
   localparam logic [21:0] RST_LOW_CYC = 22'h000190;
   // Default answer timeout in card clocks: 9 600 etu of 372 clocks
   localparam int ATR_WAIT_DEFAULT = 32'h00367E00;
   localparam logic [5:0] ATR_MAX_CHARS = 6'h21;
   localparam logic [1:0] MAX_FAULTS = 2'h3;
   // Initial character as read with direct sampling, for each convention
   localparam logic [7:0] TS_DIRECT_RAW = 8'h3B;
   localparam logic [7:0] TS_INVERSE_RAW = 8'h03;
   localparam logic [7:0] TA1_DEFAULT = 8'h11;
   localparam logic [7:0] EGT_NONE = 8'h00;
   localparam logic [7:0] EGT_MIN_DELAY = 8'hFF;
   localparam logic [7:0] WWI_DEFAULT = 8'h0A;
   // Start, 8 data and parity, then guard: 12 etu from start to start
   localparam logic [3:0] FRAME_BITS = 4'hA;
   localparam logic [3:0] GUARD_BITS = 4'h2;
   localparam logic [3:0] PARITY_BIT = 4'h9;

   typedef enum logic [2:0] {ST_OFF, ST_RST, ST_ATR, ST_READY, ST_STOPPED, ST_WAKE,
      ST_REJECT} csc_state_e;
   typedef enum logic [2:0] {PH_TS, PH_T0, PH_IF, PH_HIST, PH_TCK, PH_DONE} csc_phase_e;
endpackage

// file: rtl/csc_strm_if.sv
// Valid/ready byte stream between the host's own modules
`timescale 1ns/1ns
interface csc_strm_if #(parameter int W = 8) ();
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src(output data, output valid, input ready);
   modport snk(input data, input valid, output ready);
endinterface

// file: rtl/csc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module csc_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic val;
   } csc_sync_s;

   csc_sync_s q;
   csc_sync_s d;

   always_comb
   begin
      d = q;
      d.s1 = d_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3)
      begin
         d.val = q.s3;
      end
   end

   // Idle line is high
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '1;
      end
      else
      begin
         q <= d;
      end
   end

   assign q_o = q.val;
endmodule

// file: sim/csc_card_model.sv
// Card model answering each reset with a minimal direct-convention answer
`timescale 1ns/1ns
module csc_card_model #(
   parameter int DLY = 40
) (
   input wire logic card_clk_i,
   input wire logic card_rst_i,
   output logic io_o
);
   logic [7:0] reset_answer [2] = '{8'h3B, 8'h00};
   initial io_o = 1'b1;
   task automatic etu(input int n);
      repeat (n * 372) @(posedge card_clk_i);
   endtask
   // ==========
   // Answer after a fixed delay of DLY card clocks
   always @(posedge card_rst_i)
   begin
      repeat (DLY) @(posedge card_clk_i);
      foreach (reset_answer[i])
      begin
         for (int b = 0; b < 10; b++)
         begin
            io_o <= (b == 0) ? 1'b0 : (b == 9) ? ^reset_answer[i] : reset_answer[i][b-1];
            etu(1);
         end
         io_o <= 1'b1;
         etu(2);
      end
   end
endmodule

// file: sim/csc_host_props.sv
// Port-level checks of the card session host controller
`timescale 1ns/1ns
module csc_host_props (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic STOP_ALLOWED_I,
   input wire logic CLK_STOP_REQ_I,
   input wire logic IO_I,
   input wire logic IO_OE_N_O,
   input wire logic CARD_CLK_O,
   input wire logic CARD_RST_O,
   input wire logic TX_READY_O,
   input wire logic SESSION_READY_O,
   input wire logic SPEED_NEG_REQ_O,
   input wire logic [7:0] SPEED_CHAR_O,
   input wire logic CLK_STOPPED_O,
   input wire logic CARD_REJECTED_O
);
   logic [12:0] idle_q, wake_q;
   logic io_q, cclk_q, stop_q;
   wire cclk_rise = CARD_CLK_O & ~cclk_q;
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);
   // ==========
   // Card clocks since the wire moved and since the clock restarted
   always_ff @(posedge MCLK_I)
   begin
      io_q <= IO_I;
      cclk_q <= CARD_CLK_O;
      stop_q <= CLK_STOPPED_O;
      if (RST_I || IO_I != io_q || !IO_OE_N_O)
         idle_q <= 13'h0000;
      else if (cclk_rise && idle_q != 13'h1FFF)
         idle_q <= idle_q + 13'h0001;
      if (RST_I)
         wake_q <= 13'h1FFF;
      else if (stop_q && !CLK_STOPPED_O)
         wake_q <= 13'h0000;
      else if (cclk_rise && wake_q != 13'h1FFF)
         wake_q <= wake_q + 13'h0001;
   end
   // ==========
   // Assertions
   rst_state_a: assert property (disable iff (1'b0)
      RST_I |=> !CARD_RST_O && IO_OE_N_O && TX_READY_O && !SESSION_READY_O)
      else $error("reset state wrong");
   stop_cause_a: assert property ($rose(CLK_STOPPED_O) |->
      $past(STOP_ALLOWED_I) && $past(CLK_STOP_REQ_I))
      else $error("clock stopped without leave");
   stop_wait_a: assert property ($rose(CLK_STOPPED_O) |-> idle_q >= 13'h0744)
      else $error("clock stopped too soon");
   wake_wait_a: assert property ($fell(IO_OE_N_O) |-> wake_q >= 13'h02E8)
      else $error("sent too soon after restart");
   stop_low_a: assert property (CLK_STOPPED_O |-> !CARD_CLK_O)
      else $error("clock runs while stopped");
   clk_div_a: assert property ($rose(CARD_CLK_O) && !CLK_STOP_REQ_I |->
      CARD_CLK_O [*4] ##1 !CARD_CLK_O)
      else $error("card clock half period wrong");
   reject_a: assert property (CARD_REJECTED_O |-> !CARD_CLK_O && !CARD_RST_O)
      else $error("rejected card still driven");
   neg_req_a: assert property (SPEED_NEG_REQ_O |-> SPEED_CHAR_O != 8'h11)
      else $error("negotiation asked for default speed");
endmodule
bind csc_host csc_host_props u_csc_host_props (.MCLK_I, .RST_I, .STOP_ALLOWED_I,
   .CLK_STOP_REQ_I, .IO_I, .IO_OE_N_O, .CARD_CLK_O, .CARD_RST_O, .TX_READY_O,
   .SESSION_READY_O, .SPEED_NEG_REQ_O, .SPEED_CHAR_O, .CLK_STOPPED_O, .CARD_REJECTED_O);

// file: sim/tb_top.sv
// Bench for the card session host controller
`timescale 1ns/1ns
module tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic txv = 1'b0;
   logic req = 1'b0;
   logic neg = 1'b0;
   int n_wait = 0;
   logic [7:0] txd = 8'h00;
   logic tx_rdy, io_oe_n, io_o, cclk, crst, rdy, inv, nreq, stp, rej, card_io;
   logic [7:0] spd, wwi;
   logic [9:0] frame = {^8'hC5, 8'hC5, 1'b0};
   wire io_w = (io_oe_n | io_o) & card_io;
   int fails = 0;
   int n_checks = 0;
   always #25 mclk = ~mclk;
   csc_host #(.ATR_WAIT_CYC(20000)) u_csc_host (
      .MCLK_I(mclk), .RST_I(rst), .START_I(start), .STOP_ALLOWED_I(1'b1),
      .CLK_STOP_REQ_I(req), .NEG_DONE_I(neg), .NEG_ETU_I(10'h010),
      .TX_DATA_I(txd), .TX_VALID_I(txv), .TX_READY_O(tx_rdy), .IO_I(io_w),
      .IO_O(io_o), .IO_OE_N_O(io_oe_n), .CARD_CLK_O(cclk), .CARD_RST_O(crst),
      .RX_DATA_O(), .RX_VALID_O(), .SESSION_READY_O(rdy), .SPEED_NEG_REQ_O(nreq),
      .SPEED_CHAR_O(spd), .WWI_O(wwi), .INVERSE_O(inv), .CLK_STOPPED_O(stp),
      .CARD_REJECTED_O(rej));
   csc_card_model u_csc_card_model (.card_clk_i(cclk), .card_rst_i(crst), .io_o(card_io));
   // ==========
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic push(input logic [7:0] d);
      txd <= d;
      txv <= 1'b1;
      // Ready is read once settled, i.e. the value the next edge will sample
      #1;
      while (tx_rdy !== 1'b1)
      begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
   endtask
   task automatic summarize();
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========
   // Main sequence
   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      start <= 1'b1;
      push(8'hC5);
      push(8'h3C);
      push(8'h01);
      push(8'h80);
      txd <= 8'hEE;
      repeat (3) @(posedge mclk);
      check({7'h00, tx_rdy}, 8'h00);
      txv <= 1'b0;
      for (int i = 0; i < 90000 && rdy !== 1'b1; i++)
         @(posedge mclk);
      check({7'h00, rdy}, 8'h01);
      check({7'h00, inv}, 8'h00);
      check({7'h00, nreq}, 8'h00);
      check(spd, 8'h11);
      check(wwi, 8'h0A);
      check({6'h00, rej, stp}, 8'h00);
      // Negotiated rate: 16 card clocks of 8 master clocks per bit
      neg <= 1'b1;
      @(posedge mclk);
      neg <= 1'b0;
      for (int i = 0; i < 20000 && io_oe_n !== 1'b0; i++)
         @(posedge mclk);
      repeat (64) @(posedge mclk);
      for (int k = 0; k < 10; k++)
      begin
         check({7'h00, io_w}, {7'h00, frame[k]});
         repeat (128) @(posedge mclk);
      end
      check({7'h00, tx_rdy}, 8'h01);
      // Clock stop after the queued bytes, then a byte held back until the wake wait ends
      req <= 1'b1;
      for (int i = 0; i < 30000 && stp !== 1'b1; i++)
         @(posedge mclk);
      repeat (20) @(posedge mclk);
      check({6'h00, stp, cclk}, 8'h02);
      push(8'h5A);
      txv <= 1'b0;
      repeat (20) @(posedge mclk);
      check({7'h00, io_oe_n}, 8'h01);
      req <= 1'b0;
      for (n_wait = 0; n_wait < 20000 && io_oe_n !== 1'b0; n_wait++)
         @(posedge mclk);
      // 744 card clock rises span 743 periods of 8 master clocks
      check({7'h00, n_wait >= 5944}, 8'h01);
      summarize();
   end
   initial
   begin
      repeat (110000) @(posedge mclk);
      fails++;
      $display("[ERR] %0t run timed out", $time);
      summarize();
   end
endmodule
